// file: include/bstap_consts.vh
// Constants for the boundary-scan test access port controller.
// Included by bare name; definitions only.
`ifndef BSTAP_CONSTS_VH
`define BSTAP_CONSTS_VH
// ----------------------------------------
// Register widths
// ----------------------------------------
`define BSTAP_IR_W 8
`define BSTAP_BND_W 48
`define BSTAP_CTL_W 3
`define BSTAP_ID_W 32
// ----------------------------------------
// Reset and capture values
// ----------------------------------------
`define BSTAP_IR_RESET 8'h81
`define BSTAP_IR_CAPTURE 8'h81
`define BSTAP_CTL_RESET 3'h2
`define BSTAP_CTL_SIGCOMP 3'h2
// Identity value is arbitrary and neutral
`define BSTAP_ID_VALUE 32'h12345679
// ----------------------------------------
// Boundary cells with defined reset values
// ----------------------------------------
`define BSTAP_BND_CLR_HI 47
`define BSTAP_BND_CLR_LO 46
`define BSTAP_BND_SET_HI 45
`define BSTAP_BND_SET_LO 44
// Whole-chain reset image: cells 47-46 low, 45-44 high, rest low
`define BSTAP_BND_RESET 48'h3000_0000_0000
// ----------------------------------------
// Instruction opcodes (bit 7 is even parity)
// ----------------------------------------
`define BSTAP_OP_EXTEST 8'h00
`define BSTAP_OP_SAMPLE 8'h82
`define BSTAP_OP_IDCODE 8'h81
`define BSTAP_OP_BYPASS 8'hFF
`define BSTAP_OP_RUNT 8'h09
`define BSTAP_OP_CTLREG 8'h0A
// ----------------------------------------
// Controller states
// ----------------------------------------
`define BSTAP_ST_RESET 4'hF
`define BSTAP_ST_IDLE 4'hC
`define BSTAP_ST_SELDR 4'h7
`define BSTAP_ST_CAPDR 4'h6
`define BSTAP_ST_SHDR 4'h2
`define BSTAP_ST_EX1DR 4'h1
`define BSTAP_ST_PADR 4'h3
`define BSTAP_ST_EX2DR 4'h0
`define BSTAP_ST_UPDR 4'h5
`define BSTAP_ST_SELIR 4'h4
`define BSTAP_ST_CAPIR 4'hE
`define BSTAP_ST_SHIR 4'hA
`define BSTAP_ST_EX1IR 4'h9
`define BSTAP_ST_PAIR 4'hB
`define BSTAP_ST_EX2IR 4'h8
`define BSTAP_ST_UPIR 4'hD
`endif

// file: design/bstap_word_buf.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module bstap_word_buf #(
  parameter W = 48
) (
  input wire ref_clk,
  input wire rst_n,
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [W-1:0] slot0; // Entry 0
  reg [W-1:0] slot1; // Entry 1
  reg wrIdx; // Write index
  reg rdIdx; // Read index
  reg [1:0] count; // Words held
  wire doWrite = inValid && (count != 2'h2);
  wire doRead = (count != 2'h0) && outReady;
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = rdIdx ? slot1 : slot0;
  // Pointer and count update
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot0 <= {W{1'b0}};
      slot1 <= {W{1'b0}};
      wrIdx <= 1'b0;
      rdIdx <= 1'b0;
      count <= 2'h0;
    end else begin
      if (doWrite) begin
        if (wrIdx) begin
          slot1 <= inData;
        end else begin
          slot0 <= inData;
        end
        wrIdx <= ~wrIdx;
      end
      if (doRead) begin
        rdIdx <= ~rdIdx;
      end
      // Simultaneous read and write keep count
      if (doWrite && !doRead) begin
        count <= count + 2'h1;
      end else if (doRead && !doWrite) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/bstap_controller.v
// Test access port controller with instruction and data scan paths.
// Assumes test clock, mode and data arrive asynchronous to ref_clk and are
// synchronised here; the update word leaves through a two-entry buffer.
`include "bstap_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: sample on rising test clock, drive on falling
// RULE2: eight-bit instruction register
// RULE3: four data chains: 48, 3, 1, 32 bits
// RULE4: sixteen states stepped by mode input
// RULE5: power-up in reset state, test logic off
// RULE6: mode high five cycles reaches reset
// RULE7: reset loads instruction 10000001
// RULE8: cells 47-46 cleared, 45-44 set
// RULE9: control chain reset to 010
// RULE10: master passes idle before test operations
// RULE11: control operations run only in idle; ctlRunning here stays high one ref_clk cycle after idle is left
// RULE12: select states do nothing, leave next
// RULE13: capture-DR loads chain on leaving edge
// RULE14: shift entry drives output with bit 0
// RULE15: one shift per edge, none at entry
// RULE16: exit1 returns output to high impedance
// RULE17: return to shift without recapture
// RULE18: pause holds scan contents intact
// RULE19: update-DR latches on falling edge
// RULE20: capture-IR loads fixed 10000001
// RULE21: update-IR activates instruction on falling edge
// RULE22: only one register in scan path
// RULE23: parity bit seven; unknown acts bypass
// RULE24: bypass cell captures zero
// RULE25: control chain unchanged at capture
// RULE26: boundary chain shifts 47 down to 0
// RULE27: standard transition graph
module bstap_controller (
  input wire ref_clk,
  input wire rst_n,
  input wire testClk,
  input wire testMode,
  input wire testDataIn,
  output reg testDataOut,
  output reg testDataOutEn_n,
  output reg [3:0] tapState,
  output reg [7:0] activeInstr,
  output reg testModeActive,
  output reg [2:0] ctlOp,
  output reg ctlRunning,
  output reg updValid,
  input wire updReady,
  output reg [47:0] updWord
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] clkSync; // Test clock, two stages
  reg [1:0] modeSync; // Mode select, two stages
  reg [1:0] dataSync; // Serial data, two stages
  reg clkLast; // Previous synced clock for edges
  // Two flops per input; only stage 1 is read
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 2'h0;
      modeSync <= 2'h3;
      dataSync <= 2'h3;
      clkLast <= 1'b0;
    end else begin
      clkSync <= {clkSync[0], testClk};
      modeSync <= {modeSync[0], testMode};
      dataSync <= {dataSync[0], testDataIn};
      clkLast <= clkSync[1];
    end
  end
  wire riseEdge = clkSync[1] && !clkLast; // [RULE1]
  wire fallEdge = !clkSync[1] && clkLast; // [RULE1]
  wire tms = modeSync[1];
  wire tdi = dataSync[1];
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Next state from graph and mode level
  function [3:0] nextOf;
    input [3:0] st;
    input m;
    begin
      case (st)
        `BSTAP_ST_RESET: nextOf = m ? `BSTAP_ST_RESET : `BSTAP_ST_IDLE;
        `BSTAP_ST_IDLE: nextOf = m ? `BSTAP_ST_SELDR : `BSTAP_ST_IDLE;
        `BSTAP_ST_SELDR: nextOf = m ? `BSTAP_ST_SELIR : `BSTAP_ST_CAPDR;
        `BSTAP_ST_CAPDR: nextOf = m ? `BSTAP_ST_EX1DR : `BSTAP_ST_SHDR;
        `BSTAP_ST_SHDR: nextOf = m ? `BSTAP_ST_EX1DR : `BSTAP_ST_SHDR;
        `BSTAP_ST_EX1DR: nextOf = m ? `BSTAP_ST_UPDR : `BSTAP_ST_PADR;
        `BSTAP_ST_PADR: nextOf = m ? `BSTAP_ST_EX2DR : `BSTAP_ST_PADR;
        `BSTAP_ST_EX2DR: nextOf = m ? `BSTAP_ST_UPDR : `BSTAP_ST_SHDR;
        `BSTAP_ST_UPDR: nextOf = m ? `BSTAP_ST_SELDR : `BSTAP_ST_IDLE;
        `BSTAP_ST_SELIR: nextOf = m ? `BSTAP_ST_RESET : `BSTAP_ST_CAPIR;
        `BSTAP_ST_CAPIR: nextOf = m ? `BSTAP_ST_EX1IR : `BSTAP_ST_SHIR;
        `BSTAP_ST_SHIR: nextOf = m ? `BSTAP_ST_EX1IR : `BSTAP_ST_SHIR;
        `BSTAP_ST_EX1IR: nextOf = m ? `BSTAP_ST_UPIR : `BSTAP_ST_PAIR;
        `BSTAP_ST_PAIR: nextOf = m ? `BSTAP_ST_EX2IR : `BSTAP_ST_PAIR;
        `BSTAP_ST_EX2IR: nextOf = m ? `BSTAP_ST_UPIR : `BSTAP_ST_SHIR;
        `BSTAP_ST_UPIR: nextOf = m ? `BSTAP_ST_SELDR : `BSTAP_ST_IDLE;
        default: nextOf = `BSTAP_ST_RESET;
      endcase
    end
  endfunction
  // Even parity over all eight bits is valid
  function parityOk;
    input [7:0] op;
    begin
      parityOk = ~^op;
    end
  endfunction
  // Chain select: 0 bypass, 1 boundary, 2 control, 3 identity
  function [1:0] chainOf;
    input [7:0] op;
    begin
      if (!parityOk(op)) begin
        chainOf = 2'h0; // [RULE23]
      end else begin
        case (op)
          `BSTAP_OP_EXTEST: chainOf = 2'h1;
          `BSTAP_OP_SAMPLE: chainOf = 2'h1;
          `BSTAP_OP_RUNT: chainOf = 2'h0;
          `BSTAP_OP_CTLREG: chainOf = 2'h2;
          `BSTAP_OP_IDCODE: chainOf = 2'h3;
          default: chainOf = 2'h0; // [RULE23]
        endcase
      end
    end
  endfunction
  // ----------------------------------------
  // Controller state
  // ----------------------------------------
  wire [3:0] stNext = nextOf(tapState, tms); // [RULE27]
  // Mode high walks any state home within five edges
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tapState <= `BSTAP_ST_RESET; // [RULE5]
    end else if (riseEdge) begin
      tapState <= stNext; // [RULE4] [RULE6] [RULE12]
    end
  end
  // ----------------------------------------
  // Shift chains
  // ----------------------------------------
  reg [7:0] irShift; // Instruction shift stage [RULE2]
  reg [47:0] bndShift; // Boundary cell chain [RULE3]
  reg [2:0] ctlShift; // Boundary control chain [RULE3]
  reg bypShift; // Bypass cell [RULE3]
  reg [31:0] idShift; // Identity chain [RULE3]
  reg [47:0] bndLatch; // Boundary update latches
  wire [1:0] chain = chainOf(activeInstr);
  wire inReset = (tapState == `BSTAP_ST_RESET);
  // Capture, shift and reset on rising edges
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irShift <= `BSTAP_IR_RESET;
      bndShift <= `BSTAP_BND_RESET;
      ctlShift <= `BSTAP_CTL_RESET;
      bypShift <= 1'b0;
      idShift <= 32'h0;
    end else if (riseEdge) begin
      if (inReset) begin
        irShift <= `BSTAP_IR_RESET; // [RULE7]
        bndShift[`BSTAP_BND_CLR_HI:`BSTAP_BND_CLR_LO] <= 2'h0; // [RULE8]
        bndShift[`BSTAP_BND_SET_HI:`BSTAP_BND_SET_LO] <= 2'h3; // [RULE8]
      end
      case (tapState)
        `BSTAP_ST_CAPIR: begin
          irShift <= `BSTAP_IR_CAPTURE; // [RULE20]
        end
        `BSTAP_ST_SHIR: begin
          irShift <= {tdi, irShift[7:1]}; // [RULE15]
        end
        `BSTAP_ST_CAPDR: begin
          // Only the selected chain loads [RULE13] [RULE22]
          case (chain)
            2'h1: bndShift <= bndLatch;
            2'h3: idShift <= `BSTAP_ID_VALUE;
            2'h2: ctlShift <= ctlShift; // [RULE25]
            default: bypShift <= 1'b0; // [RULE24]
          endcase
        end
        `BSTAP_ST_SHDR: begin
          // Cell 0 nearest the output [RULE15] [RULE26]
          case (chain)
            2'h1: bndShift <= {tdi, bndShift[47:1]};
            2'h2: ctlShift <= {tdi, ctlShift[2:1]};
            2'h3: idShift <= {tdi, idShift[31:1]};
            default: bypShift <= tdi;
          endcase
        end
        // Exit and pause states hold chains [RULE17] [RULE18]
        default: begin
        end
      endcase
    end
  end
  // ----------------------------------------
  // Falling-edge outputs and updates
  // ----------------------------------------
  reg [2:0] ctlLatch; // Control operation latch
  wire inShiftIr = (tapState == `BSTAP_ST_SHIR);
  wire inShiftDr = (tapState == `BSTAP_ST_SHDR);
  reg serialBit; // Bit 0 of the path in scan
  // Pick the bit for the output pin
  always @* begin
    serialBit = 1'b0;
    if (inShiftIr) begin
      serialBit = irShift[0]; // [RULE22]
    end else begin
      case (chain)
        2'h1: serialBit = bndShift[0];
        2'h2: serialBit = ctlShift[0];
        2'h3: serialBit = idShift[0];
        default: serialBit = bypShift;
      endcase
    end
  end
  // Outputs change only on falling edges of the test clock
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      testDataOut <= 1'b0;
      testDataOutEn_n <= 1'b1;
      activeInstr <= `BSTAP_IR_RESET;
      ctlLatch <= `BSTAP_CTL_RESET;
      bndLatch <= `BSTAP_BND_RESET;
      testModeActive <= 1'b0;
      ctlOp <= `BSTAP_CTL_RESET;
    end else if (fallEdge) begin
      // Enable only while shifting; exit1 floats it [RULE14] [RULE16]
      testDataOutEn_n <= !(inShiftIr || inShiftDr);
      testDataOut <= serialBit; // [RULE14]
      if (inReset) begin
        activeInstr <= `BSTAP_IR_RESET; // [RULE7]
        ctlLatch <= `BSTAP_CTL_RESET; // [RULE9]
        ctlOp <= `BSTAP_CTL_RESET; // [RULE9]
        bndLatch[`BSTAP_BND_CLR_HI:`BSTAP_BND_CLR_LO] <= 2'h0; // [RULE8]
        bndLatch[`BSTAP_BND_SET_HI:`BSTAP_BND_SET_LO] <= 2'h3; // [RULE8]
        testModeActive <= 1'b0; // [RULE5]
      end else if (tapState == `BSTAP_ST_UPIR) begin
        activeInstr <= irShift; // [RULE21]
        // Test mode only for the drive-out instruction
        testModeActive <= (irShift == `BSTAP_OP_EXTEST);
      end else if (tapState == `BSTAP_ST_UPDR) begin
        // Identity and bypass have no latches [RULE19]
        if (chain == 2'h1) begin
          bndLatch <= bndShift;
        end else if (chain == 2'h2) begin
          // Operation output moves with its latch, not a fall later
          ctlLatch <= ctlShift;
          ctlOp <= ctlShift;
        end
      end
    end
  end
  // Operation flag follows the state every cycle, so it drops one cycle after
  // the controller leaves idle instead of half a test clock later
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlRunning <= 1'b0;
    end else begin
      ctlRunning <= (tapState == `BSTAP_ST_IDLE) && (activeInstr == `BSTAP_OP_RUNT); // [RULE11]
    end
  end
  // ----------------------------------------
  // Update word buffer
  // ----------------------------------------
  wire bufInReady; // Buffer has room
  wire bufOutValid; // Buffer has a word
  wire [47:0] bufOutData; // Head word
  reg pushReq; // Push request, held until accepted
  reg [47:0] pushWord; // Word pushed
  reg pushPend; // Push waiting for room
  // Boundary update pushes; waits while buffer is full
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pushPend <= 1'b0;
      pushWord <= 48'h0;
    end else if (fallEdge && tapState == `BSTAP_ST_UPDR && chain == 2'h1) begin
      pushPend <= 1'b1;
      pushWord <= bndShift;
    end else if (pushPend && bufInReady) begin
      pushPend <= 1'b0;
    end
  end
  always @* begin
    pushReq = pushPend;
  end
  bstap_word_buf #(.W(48)) uBuf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(pushReq),
    .inReady(bufInReady),
    .inData(pushWord),
    .outValid(bufOutValid),
    .outReady(!updValid || updReady),
    .outData(bufOutData)
  );
  // Output stage registered from buffer head
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      updValid <= 1'b0;
      updWord <= 48'h0;
    end else if (!updValid || updReady) begin
      updValid <= bufOutValid;
      updWord <= bufOutData;
    end
  end
endmodule
`default_nettype wire

// file: bench/bstap_controller_sva.sv
// Checker on the ports of the test access port controller.
// Assumes it is bound to bstap_controller and sees nothing inside it.
`include "bstap_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module bstap_controller_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic testClk,
  input wire logic testDataOut,
  input wire logic testDataOutEn_n,
  input wire logic [3:0] tapState,
  input wire logic [7:0] activeInstr,
  input wire logic [2:0] ctlOp,
  input wire logic ctlRunning,
  input wire logic updValid,
  input wire logic updReady,
  input wire logic [47:0] updWord
);
  // One domain, so one clock and one disable for all
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // -------------------------------------------
  // Output timing and scan path
  // -------------------------------------------
  property p_drive_in_shift;
    !testDataOutEn_n |-> tapState inside {`BSTAP_ST_SHDR, `BSTAP_ST_EX1DR,
      `BSTAP_ST_SHIR, `BSTAP_ST_EX1IR};
  endproperty
  a_drive_in_shift: assert property (p_drive_in_shift) else $error("driven outside shift");
  property p_release;
    $rose(testDataOutEn_n) |-> tapState inside {`BSTAP_ST_EX1DR, `BSTAP_ST_EX1IR};
  endproperty
  a_release: assert property (p_release) else $error("release outside exit1");
  property p_out_on_fall;
    $changed(testDataOut) || $changed(testDataOutEn_n) |-> !testClk && !$past(testClk);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off fall");
  property p_step_on_rise;
    $changed(tapState) |-> testClk && $past(testClk);
  endproperty
  a_step_on_rise: assert property (p_step_on_rise) else $error("state moved off rise");
  property p_select_leaves;
    tapState == `BSTAP_ST_SELDR |-> ##[1:16] tapState != `BSTAP_ST_SELDR;
  endproperty
  a_select_leaves: assert property (p_select_leaves) else $error("select held");
  property p_selir_leaves;
    tapState == `BSTAP_ST_SELIR |-> ##[1:16] tapState != `BSTAP_ST_SELIR;
  endproperty
  a_selir_leaves: assert property (p_selir_leaves) else $error("select-IR held");
  property p_reset_tri;
    tapState == `BSTAP_ST_RESET |-> testDataOutEn_n;
  endproperty
  a_reset_tri: assert property (p_reset_tri) else $error("driven in reset");
  // -------------------------------------------
  // Instruction, control chain and update word
  // -------------------------------------------
  property p_instr_moment;
    $changed(activeInstr) |-> tapState inside {`BSTAP_ST_UPIR, `BSTAP_ST_RESET};
  endproperty
  a_instr_moment: assert property (p_instr_moment) else $error("instruction moved");
  property p_ctl_moment;
    $changed(ctlOp) |-> tapState inside {`BSTAP_ST_UPDR, `BSTAP_ST_RESET};
  endproperty
  a_ctl_moment: assert property (p_ctl_moment) else $error("control chain moved");
  // Registered flag may trail the state by one cycle
  property p_run_idle;
    ctlRunning |-> activeInstr == `BSTAP_OP_RUNT && $past(tapState) == `BSTAP_ST_IDLE;
  endproperty
  a_run_idle: assert property (p_run_idle) else $error("run outside idle");
  property p_upd_cause;
    $rose(updValid) |-> tapState == `BSTAP_ST_UPDR;
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("word without update");
  property p_upd_hold;
    updValid && !updReady |=> updValid && $stable(updWord);
  endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("stalled word lost");
endmodule
bind bstap_controller bstap_controller_sva chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .testClk(testClk), .testDataOut(testDataOut), .testDataOutEn_n(testDataOutEn_n),
  .tapState(tapState), .activeInstr(activeInstr), .ctlOp(ctlOp), .ctlRunning(ctlRunning),
  .updValid(updValid), .updReady(updReady), .updWord(updWord));
`default_nettype wire

// file: bench/bstap_test_master.sv
// Model of the external test bus master.
// Assumes the bench calls its tasks between ref_clk edges; clock rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module bstap_test_master (
  output logic testClk,
  output logic testMode,
  output logic testDataIn,
  input wire logic testDataOut,
  input wire logic testDataOutEn_n
);
  // Mode and data rest at their pull-up level
  initial begin
    testClk = 1'b0;
    testMode = 1'b1;
    testDataIn = 1'b1;
  end
  // One 64 ns cycle; data set half a phase before the rise
  task automatic step(input logic mo, input logic di, output logic q);
    testMode = mo;
    testDataIn = di;
    #16 q = testDataOutEn_n ? 1'bz : testDataOut;
    testClk = 1'b1;
    #32 testClk = 1'b0;
    #16;
  endtask
  // Forced reset, then through idle before any operation
  task automatic go_idle();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// file: bench/bstap_controller_tb.sv
// Self-checking bench for the test access port controller.
// Assumes the master model drives the test pins; the bench owns the update sink.
`include "bstap_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module bstap_controller_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic updReady = 1'b0;
  wire testClk, testMode, testDataIn, testDataOut, testDataOutEn_n;
  wire testModeActive, ctlRunning, updValid;
  wire [3:0] tapState;
  wire [7:0] activeInstr;
  wire [2:0] ctlOp;
  wire [47:0] updWord;
  int errorCnt = 0;
  int testsRun = 0;
  logic [47:0] d;
  logic q;
  always #2.5 ref_clk = ~ref_clk;
  bstap_test_master master (.testClk(testClk), .testMode(testMode), .testDataIn(testDataIn),
    .testDataOut(testDataOut), .testDataOutEn_n(testDataOutEn_n));
  bstap_controller dut (.ref_clk(ref_clk), .rst_n(rst_n), .testClk(testClk),
    .testMode(testMode), .testDataIn(testDataIn), .testDataOut(testDataOut),
    .testDataOutEn_n(testDataOutEn_n), .tapState(tapState), .activeInstr(activeInstr),
    .testModeActive(testModeActive), .ctlOp(ctlOp), .ctlRunning(ctlRunning),
    .updValid(updValid), .updReady(updReady), .updWord(updWord));
  // -------------------------------------------
  // Shared tasks
  // -------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Idle to shift, n bits LSB first, optional pause after brk bits, back to idle
  task automatic scan(input bit ir, input int n, input logic [47:0] din, input int brk);
    master.step(1'b1, 1'b1, q);
    if (ir) master.step(1'b1, 1'b1, q);
    master.step(1'b0, 1'b1, q);
    master.step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      master.step(i == n - 1 || i == brk - 1, din[i], q);
      d[i] = q;
      if (i == brk - 1) begin
        master.step(1'b0, ~din[i], q);
        chk(q, 1'bz, "pause not released");
        master.step(1'b0, ~din[i], q);
        master.step(1'b1, ~din[i], q);
        master.step(1'b0, ~din[i], q);
      end
    end
    master.step(1'b1, 1'b1, q);
    master.step(1'b0, 1'b1, q);
  endtask
  task automatic load(input logic [7:0] op);
    scan(1'b1, 8, {40'h0, op}, 0);
    chk(d[7:0], `BSTAP_IR_CAPTURE, "instruction capture");
  endtask
  // -------------------------------------------
  // Scenarios
  // -------------------------------------------
  task automatic t_reset_values();
    chk(tapState, `BSTAP_ST_RESET, "reset state");
    chk(activeInstr, `BSTAP_IR_RESET, "reset instruction");
    chk(ctlOp, `BSTAP_CTL_RESET, "reset control");
    chk(testDataOutEn_n, 1'b1, "reset drive");
  endtask
  task automatic t_identity();
    master.go_idle();
    scan(1'b0, 32, 48'h0, 0);
    chk(d[31:0], `BSTAP_ID_VALUE, "identity word");
  endtask
  // Unknown even and odd parity opcodes act as the one-cell path
  task automatic t_bypass();
    logic [7:0] ops [3] = '{8'h03, 8'h01, `BSTAP_OP_BYPASS};
    foreach (ops[k]) begin
      load(ops[k]);
      scan(1'b0, 2, 48'h3, 0);
      chk(d[1:0], 2'b10, "one-cell path");
    end
    chk(activeInstr, `BSTAP_OP_BYPASS, "instruction update");
  endtask
  task automatic t_control();
    load(`BSTAP_OP_CTLREG);
    scan(1'b0, 3, 48'h5, 0);
    chk(d[2:0], `BSTAP_CTL_RESET, "control capture");
    chk(ctlOp, 3'h5, "control update");
    load(`BSTAP_OP_RUNT);
    chk(ctlRunning, 1'b1, "run in idle");
    master.step(1'b1, 1'b1, q);
    chk(ctlRunning, 1'b0, "run outside idle");
    master.step(1'b0, 1'b1, q);
    master.step(1'b0, 1'b1, q);
    repeat (5) master.step(1'b1, 1'b1, q);
    chk(tapState, `BSTAP_ST_RESET, "forced reset");
    master.step(1'b1, 1'b1, q);
    chk(activeInstr, `BSTAP_IR_RESET, "instruction after reset");
    chk(ctlOp, `BSTAP_CTL_RESET, "control after reset");
  endtask
  // Two updates while the sink stalls, then drain
  task automatic t_boundary();
    master.go_idle();
    load(`BSTAP_OP_EXTEST);
    chk(testModeActive, 1'b1, "test mode");
    scan(1'b0, 48, 48'hA5C30F1E9B47, 20);
    chk(d[47:44], 4'h3, "benign cells");
    scan(1'b0, 48, 48'h3C96E1D27B08, 20);
    chk(d, 48'hA5C30F1E9B47, "latched word");
    chk(updWord, 48'hA5C30F1E9B47, "oldest word");
    @(negedge ref_clk);
    updReady = 1'b1;
    @(negedge ref_clk);
    chk(updWord, 48'h3C96E1D27B08, "second word");
    @(negedge ref_clk);
    chk(updValid, 1'b0, "buffer empty");
    load(`BSTAP_OP_SAMPLE);
    chk(testModeActive, 1'b0, "sample leaves test mode");
    scan(1'b0, 48, 48'h0, 0);
    chk(d, 48'h3C96E1D27B08, "sample capture");
  endtask
  // -------------------------------------------
  // Run control
  // -------------------------------------------
  task automatic finalReport();
    if (errorCnt == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Roughly 350 test clock cycles expected; generous limit
  initial begin
    #200000;
    errorCnt++;
    finalReport();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset_values();
    t_identity();
    t_bypass();
    t_control();
    t_boundary();
    finalReport();
  end
endmodule
`default_nettype wire
